// *** core/psc_map.svh ***
/*
  Constants of the program level system control block: instruction codes,
  internal register codes, internal interrupt bits, reset values, timing.
  Assumes a 16-bit instruction word as seen by the CPU decode stage.
*/
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

// Basic I/O transfer: top five bits of the word, address in bits 10..0
`define PSC_OP_IOX_TOP    5'h1D
`define PSC_OP_IO_TRANSFER_WIDE_OP       16'hD10D
`define PSC_OP_OPERATOR_COMM_OP      16'hD100
`define PSC_OP_IRQ_OFF    16'hD101
`define PSC_OP_IRQ_ON     16'hD102
`define PSC_OP_PAGE_OFF   16'hD104
`define PSC_OP_WIDE_SET   16'hD106
`define PSC_OP_WIDE_CLR   16'hD107
`define PSC_OP_PAGE_ON    16'hD108
`define PSC_OP_BOTH_ON    16'hD10A
`define PSC_OP_BOTH_OFF   16'hD10B
// Wait: top byte, low byte is a free number
`define PSC_OP_WAIT_TOP   8'hD2
// Identify, one code per vectored level
`define PSC_OP_IDENT10    16'hC784
`define PSC_OP_IDENT11    16'hC789
`define PSC_OP_IDENT12    16'hC792
`define PSC_OP_IDENT13    16'hC7A3
// Accumulator transfers: top byte, sub-op in bits 7..6, register in 3..0
`define PSC_OP_XFER_TOP   8'hD0
`define PSC_SUB_READ      2'h0
`define PSC_SUB_WRITE     2'h1
`define PSC_SUB_MCLR      2'h2
`define PSC_SUB_MSET      2'h3

// Internal register codes
`define PSC_RC_PCR        4'h3
`define PSC_RC_PVL        4'h4
`define PSC_RC_IIX        4'h5
`define PSC_RC_PID        4'h6
`define PSC_RC_PIE        4'h7

// Internal interrupt enable bits and codes
`define PSC_IIE_PRIV_BIT  4
`define PSC_IIE_IOX_BIT   7
`define PSC_IIC_PRIV      4'h4
`define PSC_IIC_IOX       4'h7
`define PSC_LVL_INTERNAL  14

// Reset values
`define PSC_MASK_RESET    16'h0000

// Timing
`define PSC_CLK_NS          100
`define PSC_IO_STROBE_NS    500
`define PSC_IO_STROBE_CYC   ((`PSC_IO_STROBE_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_IDENT_WIN_NS    2000
`define PSC_IDENT_WIN_CYC   (`PSC_IDENT_WIN_NS / `PSC_CLK_NS)

`endif

// *** core/psc_pkg.sv ***
/*
  Types of the program level system control block.
  Assumes psc_map.svh for all numeric constants.
*/
package psc_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    PSC_IDLE   = 3'b000,
    PSC_IOSTRB = 3'b001,
    PSC_IDWAIT = 3'b010,
    PSC_HALTED = 3'b011
  } psc_fsm_t;

  // Instruction handed over by decode
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
    logic [15:0] aReg;
    logic [15:0] tReg;
  } psc_instr_t;

  // Whole state of the block
  typedef struct packed {
    psc_fsm_t    fsm;
    logic [15:0] enMask;
    logic [15:0] reqFlags;
    logic [3:0]  curLevel;
    logic [3:0]  prevLevel;
    logic        irqOn;
    logic        pagingOn;
    logic        wideAddr;
    logic        runLamp;
    logic [15:0] paging_control_reg;
    logic [15:0] internal_irq_enable;
    logic [3:0]  internal_irq_code;
    logic [7:0]  cnt;
    logic        ioStrobe;
    logic [15:0] ioAddr;
    logic [15:0] ioData;
    logic        identReq;
    logic [1:0]  identLevel;
    logic        done;
    logic        aWe;
    logic [15:0] aOut;
    logic        opcomEvent;
    logic        privFault;
    logic [4:0]  extS1;
    logic [4:0]  extS2;
    logic        idvS1;
    logic        idvS2;
    logic [8:0]  idcS1;
    logic [8:0]  idcS2;
    logic        btnS1;
    logic        btnS2;
    logic        btnPrev;
  } psc_state_t;

endpackage : psc_pkg

// *** core/psc_core.sv ***
/*
  Program level system control: I/O transfer strobes, 16-level priority
  selection, vectored identify, paging and wide address controls, operator
  communication and wait. Assumes decode holds an instruction until done,
  and that pins arriving from the bus are asynchronous to sys_clk.
*/
// Behaviour
// RULE1 - Basic transfer addresses from instruction bits 10..0
// RULE2 - Wide transfer takes 16-bit address from T
// RULE3 - System control instructions need privileged state
// RULE4 - Sixteen levels, fifteen highest, zero lowest
// RULE5 - Fixed level roles: fast, internal, vectored, programs
// RULE6 - Hardware may request only levels 15, 13..10
// RULE7 - Enable mask software only; requests both
// RULE8 - Running level is highest enabled requested level
// RULE9 - Reset clears both masks, level zero
// RULE10 - Enable resumes at top level, lamp lit
// RULE11 - Disable freezes level, lamp off
// RULE12 - Four identify codes for levels 10..13
// RULE13 - Identify returns nine-bit code, upper bits zero
// RULE14 - No answer: A kept, level 14 error
// RULE15 - Slot order picks device; line holds
// RULE16 - Paging on applies table from control register
// RULE17 - Paging off only in rings 3, 2
// RULE18 - Combined ops switch paging and interrupts together
// RULE19 - Wide mode selects 24-bit, status bit 13
// RULE20 - Operator op equals pressing panel button
// RULE21 - Wait with interrupts off halts, lamp off
// RULE22 - Wait with interrupts on gives up level
// RULE23 - Masked clear and set by A ones
// RULE24 - Unprivileged attempt suppressed, raises level 14
`include "psc_map.svh"
`timescale 1ns/100ps
`default_nettype none

module psc_core (
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire psc_pkg::psc_instr_t instr,      // Instruction from decode
  input  wire logic              privMode,     // Ring 2/3 or stop mode
  input  wire logic [1:0]        ringBits,     // Current ring
  input  wire logic              consoleResume,// Exclamation typed, one cycle
  input  wire logic [4:0]        extReq,       // Pins: levels 10..13 and 15
  input  wire logic              identValid,   // Pin: device answers identify
  input  wire logic [8:0]        identCode,    // Pin: answering device code
  input  wire logic              opcomButton,  // Pin: front panel button
  output logic                   done,         // Instruction finished
  output logic                   aWe,          // Write aOut to A
  output logic [15:0]            aOut,
  output logic                   ioStrobe,     // Device register select
  output logic [15:0]            ioAddr,
  output logic [15:0]            ioData,
  output logic                   identReq,
  output logic [1:0]             identLevel,   // 0..3 for levels 10..13
  output logic [3:0]             curLevel,
  output logic [3:0]             prevLevel,
  output logic [15:0]            levelEnableMask,
  output logic [15:0]            levelRequestFlags,
  output logic                   irqLamp,
  output logic                   runLamp,
  output logic                   pagingOn,
  output logic [15:0]            pageTableSel,
  output logic                   wideAddr,     // Also status bit 13
  output logic                   opcomEvent,
  output logic                   privFault
);

  psc_pkg::psc_state_t st_q;   // Registered state
  psc_pkg::psc_state_t st_d;   // Next state

  // Reset image: masks clear, level zero, lamp on
  localparam psc_pkg::psc_state_t PSC_RST = '{fsm: psc_pkg::PSC_IDLE,
    enMask: `PSC_MASK_RESET, reqFlags: `PSC_MASK_RESET, runLamp: 1'b1, default: '0};

  // Highest set bit, zero when none
  function automatic logic [3:0] pscHighest(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : pscHighest

  logic [15:0] hiSrc;     // Eligible levels
  logic [3:0]  hiPend;    // Winner among them
  logic [15:0] hwSet;     // Synchronised external requests
  logic        take;      // Instruction accepted this cycle
  logic [15:0] w;         // Shorthand for the word
  logic        isIox;
  logic        isIoxt;
  logic        isIdent;
  logic        isWait;
  logic        isXfer;
  logic        isCtl;
  logic        isSys;
  logic [1:0]  idSel;

  assign hiSrc  = st_q.enMask & st_q.reqFlags;
  assign hiPend = pscHighest(hiSrc); // RULE8 RULE4
  // Only 15 and 13..10 have pins; 14 is internal, 9..0 software
  assign hwSet  = {st_q.extS2[4], 1'b0, st_q.extS2[3:0], 10'h000}; // RULE6 RULE5
  assign take   = (st_q.fsm == psc_pkg::PSC_IDLE) && instr.valid;
  assign w      = instr.word;

  // Decode
  assign isIox   = w[15:11] == `PSC_OP_IOX_TOP;
  assign isIoxt  = w == `PSC_OP_IO_TRANSFER_WIDE_OP;
  assign isIdent = (w == `PSC_OP_IDENT10) || (w == `PSC_OP_IDENT11) ||
                   (w == `PSC_OP_IDENT12) || (w == `PSC_OP_IDENT13); // RULE12
  assign isWait  = w[15:8] == `PSC_OP_WAIT_TOP;
  assign isXfer  = (w[15:8] == `PSC_OP_XFER_TOP) && (w[5:4] == 2'h0);
  assign isCtl   = (w == `PSC_OP_OPERATOR_COMM_OP) || (w == `PSC_OP_IRQ_OFF) ||
                   (w == `PSC_OP_IRQ_ON) || (w == `PSC_OP_PAGE_OFF) ||
                   (w == `PSC_OP_WIDE_SET) || (w == `PSC_OP_WIDE_CLR) ||
                   (w == `PSC_OP_PAGE_ON) || (w == `PSC_OP_BOTH_ON) ||
                   (w == `PSC_OP_BOTH_OFF);
  // Every op handled here is privileged; monitor call lives elsewhere
  assign isSys   = isIox || isIoxt || isIdent || isWait || isXfer || isCtl;
  assign idSel   = (w == `PSC_OP_IDENT10) ? 2'h0 :
                   (w == `PSC_OP_IDENT11) ? 2'h1 :
                   (w == `PSC_OP_IDENT12) ? 2'h2 : 2'h3;

  // Next-state logic
  always_comb begin
    logic [15:0] intSet;
    intSet = 16'h0000;
    st_d = st_q;
    st_d.done       = 1'b0;
    st_d.aWe        = 1'b0;
    st_d.privFault  = 1'b0;
    // Synchronisers: stage one only feeds stage two
    st_d.extS1   = extReq;
    st_d.extS2   = st_q.extS1;
    st_d.idvS1   = identValid;
    st_d.idvS2   = st_q.idvS1;
    st_d.idcS1   = identCode;
    st_d.idcS2   = st_q.idcS1;
    st_d.btnS1   = opcomButton;
    st_d.btnS2   = st_q.btnS1;
    st_d.btnPrev = st_q.btnS2;
    // Panel button edge; the instruction joins below
    st_d.opcomEvent = st_q.btnS2 && !st_q.btnPrev;
    // Level follows the masks only while interrupts are on
    if (st_q.irqOn) begin
      st_d.curLevel = hiPend; // RULE8 RULE10
    end // else held: RULE11

    unique case (st_q.fsm)
      psc_pkg::PSC_IDLE: begin
        if (take) begin
          if (isSys && !privMode) begin
            // Suppressed, internal interrupt instead
            st_d.privFault = 1'b1; // RULE3 RULE24
            st_d.done      = 1'b1;
            st_d.internal_irq_code       = `PSC_IIC_PRIV;
            st_d.prevLevel = st_q.curLevel;
            intSet[`PSC_LVL_INTERNAL] = 1'b1; // RULE24
          end else if (isIox || isIoxt) begin
            // Strobe length fixed by the bus timing constant
            st_d.ioAddr   = isIoxt ? instr.tReg : {5'h00, w[10:0]}; // RULE1 RULE2
            st_d.ioData   = instr.aReg;
            st_d.ioStrobe = 1'b1;
            st_d.cnt      = 8'(`PSC_IO_STROBE_CYC - 1);
            st_d.fsm      = psc_pkg::PSC_IOSTRB;
          end else if (isIdent) begin
            st_d.identReq   = 1'b1;
            st_d.identLevel = idSel; // RULE12
            st_d.cnt        = 8'(`PSC_IDENT_WIN_CYC - 1);
            st_d.fsm        = psc_pkg::PSC_IDWAIT;
          end else if (isWait) begin
            if (!st_q.irqOn) begin
              // Programmed stop until console resume
              st_d.runLamp = 1'b0; // RULE21
              st_d.fsm     = psc_pkg::PSC_HALTED;
            end else begin
              // Give up priority; level zero wait is a no-op
              if (st_q.curLevel != 4'h0) begin
                st_d.reqFlags[st_q.curLevel] = 1'b0; // RULE22
              end
              st_d.done = 1'b1;
            end
          end else if (isXfer) begin
            st_d.done = 1'b1;
            unique case (w[7:6])
              `PSC_SUB_READ: begin
                st_d.aWe = 1'b1;
                // Codes other than PID, PIE, PVL and IIX read as zero
                unique case (w[3:0])
                  `PSC_RC_PID: st_d.aOut = st_q.reqFlags;
                  `PSC_RC_PIE: st_d.aOut = st_q.enMask;
                  `PSC_RC_PVL: st_d.aOut = {12'h000, st_q.prevLevel};
                  `PSC_RC_IIX: st_d.aOut = {12'h000, st_q.internal_irq_code};
                  default:     st_d.aOut = 16'h0000;
                endcase
              end
              `PSC_SUB_WRITE: begin
                if (w[3:0] == `PSC_RC_PID) st_d.reqFlags = instr.aReg; // RULE7
                if (w[3:0] == `PSC_RC_PIE) st_d.enMask = instr.aReg; // RULE7
                if (w[3:0] == `PSC_RC_IIX) st_d.internal_irq_enable = instr.aReg;
                if (w[3:0] == `PSC_RC_PCR) st_d.paging_control_reg = instr.aReg;
              end
              `PSC_SUB_MCLR: begin
                if (w[3:0] == `PSC_RC_PID) st_d.reqFlags = st_q.reqFlags & ~instr.aReg; // RULE23
                if (w[3:0] == `PSC_RC_PIE) st_d.enMask = st_q.enMask & ~instr.aReg; // RULE23
              end
              `PSC_SUB_MSET: begin
                if (w[3:0] == `PSC_RC_PID) st_d.reqFlags = st_q.reqFlags | instr.aReg; // RULE23
                if (w[3:0] == `PSC_RC_PIE) st_d.enMask = st_q.enMask | instr.aReg; // RULE23
              end
            endcase
          end else if (isCtl) begin
            st_d.done = 1'b1;
            if ((w == `PSC_OP_IRQ_ON) || (w == `PSC_OP_BOTH_ON)) begin
              st_d.irqOn = 1'b1; // RULE10 RULE18
            end
            if ((w == `PSC_OP_IRQ_OFF) || (w == `PSC_OP_BOTH_OFF)) begin
              st_d.irqOn = 1'b0; // RULE11 RULE18
            end
            if ((w == `PSC_OP_PAGE_ON) || (w == `PSC_OP_BOTH_ON)) begin
              st_d.pagingOn = 1'b1; // RULE16 RULE18
            end
            if ((w == `PSC_OP_PAGE_OFF) || (w == `PSC_OP_BOTH_OFF)) begin
              if (ringBits[1]) begin
                // Protection drops with paging
                st_d.pagingOn = 1'b0; // RULE17
              end else begin
                // Low rings may not leave paging
                st_d.privFault = 1'b1; // RULE17
                st_d.internal_irq_code       = `PSC_IIC_PRIV;
                st_d.prevLevel = st_q.curLevel;
                intSet[`PSC_LVL_INTERNAL] = 1'b1;
              end
            end
            if (w == `PSC_OP_WIDE_SET) st_d.wideAddr = 1'b1; // RULE19
            if (w == `PSC_OP_WIDE_CLR) st_d.wideAddr = 1'b0; // RULE19
            if (w == `PSC_OP_OPERATOR_COMM_OP) st_d.opcomEvent = 1'b1; // RULE20
          end else begin
            // Not ours: release decode at once
            st_d.done = 1'b1;
          end
        end
      end
      psc_pkg::PSC_IOSTRB: begin
        if (st_q.cnt == 8'h00) begin
          st_d.ioStrobe = 1'b0;
          st_d.done     = 1'b1;
          st_d.fsm      = psc_pkg::PSC_IDLE;
        end else begin
          st_d.cnt = st_q.cnt - 8'h01;
        end
      end
      psc_pkg::PSC_IDWAIT: begin
        if (st_q.idvS2 && (st_q.cnt < 8'(`PSC_IDENT_WIN_CYC - 2))) begin
          // Slot order chose it; first two cycles may echo the last answer
          st_d.aOut     = {7'h00, st_q.idcS2}; // RULE13 RULE15
          st_d.aWe      = 1'b1;
          st_d.identReq = 1'b0;
          st_d.done     = 1'b1;
          st_d.fsm      = psc_pkg::PSC_IDLE;
        end else if (st_q.cnt == 8'h00) begin
          // Nobody answered: A untouched
          st_d.identReq = 1'b0; // RULE14
          st_d.done     = 1'b1;
          st_d.fsm      = psc_pkg::PSC_IDLE;
          if (st_q.internal_irq_enable[`PSC_IIE_IOX_BIT]) begin
            st_d.internal_irq_code       = `PSC_IIC_IOX;
            st_d.prevLevel = st_q.curLevel;
            intSet[`PSC_LVL_INTERNAL] = 1'b1; // RULE14
          end
        end else begin
          st_d.cnt = st_q.cnt - 8'h01;
        end
      end
      psc_pkg::PSC_HALTED: begin
        if (consoleResume) begin
          st_d.runLamp = 1'b1; // RULE21
          st_d.done    = 1'b1;
          st_d.fsm     = psc_pkg::PSC_IDLE;
        end
      end
      default: st_d.fsm = psc_pkg::PSC_IDLE;
    endcase
    // Hardware sets applied last so they beat a software clear
    st_d.reqFlags = st_d.reqFlags | hwSet | intSet; // RULE7 RULE15
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= PSC_RST; // RULE9
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs, all straight from the state register
  assign done              = st_q.done;
  assign aWe               = st_q.aWe;
  assign aOut              = st_q.aOut;
  assign ioStrobe          = st_q.ioStrobe;
  assign ioAddr            = st_q.ioAddr;
  assign ioData            = st_q.ioData;
  assign identReq          = st_q.identReq;
  assign identLevel        = st_q.identLevel;
  assign curLevel          = st_q.curLevel;
  assign prevLevel         = st_q.prevLevel;
  assign levelEnableMask   = st_q.enMask;
  assign levelRequestFlags = st_q.reqFlags;
  assign irqLamp           = st_q.irqOn;
  assign runLamp           = st_q.runLamp;
  assign pagingOn          = st_q.pagingOn;
  assign pageTableSel      = st_q.paging_control_reg;
  assign wideAddr          = st_q.wideAddr;
  assign opcomEvent        = st_q.opcomEvent;
  assign privFault         = st_q.privFault;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_ioStart;
    take && privMode && isIox;
  endsequence
  sequence s_strobeHeld;
    ioStrobe [*5] ##1 !ioStrobe;
  endsequence

  property p_levelTracks;
    irqLamp |=> curLevel == $past(hiPend);
  endproperty
  a_levelTracks: assert property (p_levelTracks) else $error("level not highest eligible"); // RULE8

  property p_levelFrozen;
    !irqLamp |=> $stable(curLevel);
  endproperty
  a_levelFrozen: assert property (p_levelFrozen) else $error("level moved while disabled"); // RULE11

  property p_privFault;
    (take && isSys && !privMode) |=> privFault && done && levelRequestFlags[14] && !ioStrobe;
  endproperty
  a_privFault: assert property (p_privFault) else $error("unprivileged op not suppressed"); // RULE24

  property p_ioxStrobe;
    s_ioStart |=> (ioAddr == {5'h00, $past(instr.word[10:0])}) and s_strobeHeld;
  endproperty
  a_ioxStrobe: assert property (p_ioxStrobe) else $error("basic transfer address or strobe wrong"); // RULE1

  property p_identHit;
    (st_q.fsm == psc_pkg::PSC_IDWAIT && st_q.idvS2 && st_q.cnt < 8'(`PSC_IDENT_WIN_CYC - 2))
      |=> aWe && aOut[15:9] == 7'h00 && done;
  endproperty
  a_identHit: assert property (p_identHit) else $error("identify answer malformed"); // RULE13

  property p_identMiss;
    (st_q.fsm == psc_pkg::PSC_IDWAIT && !st_q.idvS2 && st_q.cnt == 8'h00) |=> !aWe && done && !identReq;
  endproperty
  a_identMiss: assert property (p_identMiss) else $error("identify miss wrote A"); // RULE14

  property p_wideSet;
    (take && privMode && w == `PSC_OP_WIDE_SET) |=> wideAddr;
  endproperty
  a_wideSet: assert property (p_wideSet) else $error("wide mode not set"); // RULE19

  property p_waitHalt;
    (take && privMode && isWait && !irqLamp) |=> !runLamp && !done;
  endproperty
  a_waitHalt: assert property (p_waitHalt) else $error("wait did not halt"); // RULE21

  property p_resetClear;
    disable iff (1'b0) srst |=> levelEnableMask == 16'h0000 && curLevel == 4'h0;
  endproperty
  a_resetClear: assert property (p_resetClear) else $error("reset left masks set"); // RULE9

endmodule : psc_core

`default_nettype wire

// *** test/psc_dev_model.sv ***
/*
  Bus-side model of the peripheral controllers: level request pins and
  answers to vectored identify. Assumes the bench arms slots between
  instructions, at the falling clock edge.
*/
`timescale 1ns/100ps
`default_nettype none

module psc_dev_model (
  input  wire logic       sys_clk,
  input  wire logic       identReq,
  input  wire logic [1:0] identLevel,
  output logic            identValid,
  output logic [8:0]      identCode,
  output logic [4:0]      extReq
);
  logic [7:0] pend;      // Slot wants service
  logic [2:0] lvl [8];   // Line per slot, 4 is level 15
  logic [8:0] code [8];  // Code per slot
  int         lat;       // Answer delay, prompt or slow
  int         cnt;       // Cycles since identify seen
  int         sel;       // Slot that answers

  initial begin
    pend = 8'h00;
    lat = 1;
    cnt = 0;
    sel = 8;
    identValid = 1'b0;
    identCode = 9'h0AA;
  end

  // Arm one slot; lower index means nearer slot
  task automatic arm(input int i, input logic [2:0] l, input logic [8:0] c);
    lvl[i] = l;
    code[i] = c;
    pend[i] = 1'b1;
  endtask : arm

  // Only the five external lines exist; a line holds while any slot waits
  always_comb begin
    extReq = 5'h00;
    for (int i = 0; i < 8; i++) if (pend[i]) extReq[lvl[i]] = 1'b1;
  end

  // Nearest slot answers; it drops its request once served
  always @(posedge sys_clk) begin
    if (identReq !== 1'b1) begin
      if (identValid) pend[sel] <= 1'b0;
      identValid <= 1'b0;
      identCode <= ~identCode;  // Released lines wander
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
      if (cnt == lat) begin
        sel = 8;
        for (int i = 7; i >= 0; i--) if (pend[i] && lvl[i] == {1'b0, identLevel}) sel = i;
        if (sel < 8) identValid <= 1'b1;
        identCode <= (sel < 8) ? code[sel] : ~identCode;
      end else if (!identValid) begin
        identCode <= ~identCode;
      end
    end
  end
endmodule : psc_dev_model

`default_nettype wire

// *** test/psc_core_tb_top.sv ***
/*
  Self-checking bench for psc_core: drives decode-side instructions and
  checks levels, strobes and A results. Assumes psc_dev_model on the bus.
*/
`include "psc_map.svh"
`timescale 1ns/100ps
`default_nettype none

module psc_core_tb_top;
  logic                sys_clk, srst, privMode, consoleResume, opcomButton;
  logic [1:0]          ringBits, identLevel;
  psc_pkg::psc_instr_t instr;
  logic                done, aWe, ioStrobe, identReq, identValid, irqLamp, runLamp;
  logic                pagingOn, wideAddr, opcomEvent, privFault, ev, flt, halted;
  logic [15:0]         aOut, ioAddr, ioData, levelEnableMask, levelRequestFlags;
  logic [15:0]         pageTableSel, capAddr, capData, r, m;
  logic [3:0]          curLevel, prevLevel;
  logic [4:0]          extReq;
  logic [8:0]          identCode;
  logic [8:0]          cd [5];       // Device codes
  logic [15:0]         expQ [$];     // A results still owed
  logic [15:0]         idc [4] = '{`PSC_OP_IDENT10, `PSC_OP_IDENT11, `PSC_OP_IDENT12, `PSC_OP_IDENT13};
  logic [15:0]         ops [7] = '{`PSC_OP_PAGE_ON, `PSC_OP_PAGE_OFF, `PSC_OP_BOTH_ON, `PSC_OP_BOTH_OFF,
                                   `PSC_OP_WIDE_SET, `PSC_OP_WIDE_CLR, `PSC_OP_OPERATOR_COMM_OP};
  logic [3:0]          exps [7] = '{4'h8, 4'h0, 4'hC, 4'h0, 4'h2, 4'h0, 4'h1};  // Paging, irq, wide, event
  int                  err_total, cmp_count, strb, i, L, kd;

  psc_core dut (.sys_clk, .srst, .instr, .privMode, .ringBits, .consoleResume, .extReq, .identValid,
    .identCode, .opcomButton, .done, .aWe, .aOut, .ioStrobe, .ioAddr, .ioData, .identReq, .identLevel,
    .curLevel, .prevLevel, .levelEnableMask, .levelRequestFlags, .irqLamp, .runLamp, .pagingOn,
    .pageTableSel, .wideAddr, .opcomEvent, .privFault);
  psc_dev_model dev (.sys_clk, .identReq, .identLevel, .identValid, .identCode, .extReq);

  function automatic logic [3:0] hi(input logic [15:0] v);
    hi = 4'h0;
    for (int j = 0; j < 16; j++) if (v[j]) hi = 4'(j);
  endfunction : hi

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : idle

  // One instruction: valid for the take edge only, fields held until done
  task automatic run(input logic [15:0] w, input logic [15:0] a, input logic [15:0] t, input int rs);
    int k;
    @(posedge sys_clk);
    instr <= '{1'b1, w, a, t};
    strb = 0;
    ev = 1'b0;
    flt = 1'b0;
    halted = 1'b0;
    for (k = 0; k < 80; k++) begin
      @(posedge sys_clk);
      instr.valid <= 1'b0;
      consoleResume <= (k == rs);
      @(negedge sys_clk);
      if (ioStrobe === 1'b1 && strb == 0) capAddr = ioAddr;
      if (ioStrobe === 1'b1 && strb == 0) capData = ioData;
      if (ioStrobe === 1'b1) strb++;
      if (opcomEvent === 1'b1) ev = 1'b1;
      if (privFault === 1'b1) flt = 1'b1;
      if (runLamp === 1'b0) halted = 1'b1;
      if (done === 1'b1) break;
    end
    kd = k;
    if (k == 80) chk(16'h0000, 16'h0001);  // No completion
  endtask : run

  task automatic conclude;
    if (expQ.size() != 0) err_total++;
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  // Every A write is matched, in order, with the driver's prediction
  always @(negedge sys_clk) begin
    if (aWe === 1'b1 && expQ.size() == 0) chk(aOut ^ 16'hFFFF, aOut);  // Unexpected write
    else if (aWe === 1'b1) chk(aOut, expQ.pop_front());
  end

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Watchdog, well past the test length
  initial begin
    repeat (30000) @(posedge sys_clk);
    err_total++;
    conclude();
  end

  initial begin
    srst = 1'b1;
    privMode = 1'b1;
    ringBits = 2'h3;
    consoleResume = 1'b0;
    opcomButton = 1'b0;
    instr = '0;
    err_total = 0;
    cmp_count = 0;
    void'($urandom(32'h6eb57a6a));
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    idle(1);
    chk(levelEnableMask | levelRequestFlags, 16'h0000);
    chk({10'h000, runLamp, irqLamp, curLevel}, 16'h0020);
    // Mask writes, masked clear and set, read back
    r = 16'($urandom());
    m = 16'($urandom());
    run(16'hD047, r, 16'h0000, -1);
    run(16'hD087, m, 16'h0000, -1);
    expQ.push_back(r & ~m);
    run(16'hD007, 16'h0000, 16'h0000, -1);
    run(16'hD0C6, m, 16'h0000, -1);
    expQ.push_back(m);
    run(16'hD006, 16'h0000, 16'h0000, -1);
    // Level choice with interrupts on, frozen with them off
    for (i = 0; i < 4; i++) begin
      r = 16'($urandom());
      m = 16'($urandom()) & 16'hBFFF;
      run(16'hD047, r, 16'h0000, -1);
      run(16'hD046, m, 16'h0000, -1);
      run(`PSC_OP_IRQ_ON, 16'h0000, 16'h0000, -1);
      idle(3);
      chk({11'h000, irqLamp, curLevel}, {11'h001, hi(r & m)});
      run(`PSC_OP_IRQ_OFF, 16'h0000, 16'h0000, -1);
      run(16'hD046, ~m, 16'h0000, -1);
      idle(3);
      chk({11'h000, irqLamp, curLevel}, {11'h000, hi(r & m)});
    end
    // Short and wide device register transfers
    r = 16'($urandom());
    m = {5'h00, 11'($urandom())};
    run({`PSC_OP_IOX_TOP, m[10:0]}, r, 16'h0000, -1);
    chk(16'(strb), 16'h0005);
    chk(capAddr, m);
    chk(capData, r);
    run(`PSC_OP_IO_TRANSFER_WIDE_OP, m, r, -1);
    chk(capAddr, r);
    // Vectored identify, two devices share level 11
    run(16'hD045, 16'h0080, 16'h0000, -1);
    run(16'hD086, 16'hFFFF, 16'h0000, -1);
    for (i = 0; i < 5; i++) cd[i] = 9'($urandom());
    for (i = 0; i < 5; i++) dev.arm(i, (i == 4) ? 3'h1 : 3'(i), cd[i]);
    dev.arm(5, 3'h4, 9'h000);
    idle(6);
    chk(levelRequestFlags, 16'hBC00);
    dev.pend[5] = 1'b0;
    for (i = 0; i < 6; i++) begin
      dev.lat = 1 + 3 * i;
      L = (i > 3) ? 1 : i;
      if (i < 5) expQ.push_back({7'h00, cd[i]});
      run(idc[L], 16'h0000, 16'h0000, -1);
    end
    chk(levelRequestFlags & 16'h4000, 16'h4000);
    // Giving up priority level by level, ignored on level 0
    run(16'hD086, 16'hFFFF, 16'h0000, -1);
    run(16'hD047, 16'hFFFF, 16'h0000, -1);
    r = (16'($urandom()) & 16'h03FF) | 16'h0001;
    run(16'hD046, r, 16'h0000, -1);
    run(`PSC_OP_IRQ_ON, 16'h0000, 16'h0000, -1);
    for (i = 0; i < 11; i++) begin
      idle(2);
      L = hi(r);
      if (L != 0) r[L] = 1'b0;
      run({`PSC_OP_WAIT_TOP, 8'($urandom())}, 16'h0000, 16'h0000, -1);
      idle(2);
      chk(levelRequestFlags, r);
      chk({12'h000, curLevel}, {12'h000, hi(r)});
    end
    // Programmed halt until the console resumes it
    run(`PSC_OP_IRQ_OFF, 16'h0000, 16'h0000, -1);
    run({`PSC_OP_WAIT_TOP, 8'h07}, 16'h0000, 16'h0000, 6);
    chk({14'h0000, halted, kd >= 6}, 16'h0003);
    // Paging, combined, wide address and operator controls
    for (i = 0; i < 7; i++) begin
      run(ops[i], 16'h0000, 16'h0000, -1);
      idle(2);
      chk({12'h000, pagingOn, irqLamp, wideAddr, ev}, {12'h000, exps[i]});
    end
    r = 16'($urandom());
    run(16'hD043, r, 16'h0000, -1);
    chk(pageTableSel, r);
    // Refusals: wrong ring, then unprivileged state
    run(`PSC_OP_PAGE_ON, 16'h0000, 16'h0000, -1);
    @(posedge sys_clk);
    ringBits <= 2'h1;
    run(`PSC_OP_PAGE_OFF, 16'h0000, 16'h0000, -1);
    chk({14'h0000, flt, pagingOn}, 16'h0003);
    run(16'hD086, 16'hFFFF, 16'h0000, -1);
    @(posedge sys_clk);
    privMode <= 1'b0;
    run({`PSC_OP_IOX_TOP, 11'h123}, 16'h0000, 16'h0000, -1);
    chk({15'h0000, flt}, 16'(strb) + 16'h0001);
    run(`PSC_OP_IRQ_ON, 16'h0000, 16'h0000, -1);
    idle(2);
    chk({13'h0000, flt, irqLamp, levelRequestFlags[14]}, 16'h0005);
    conclude();
  end
endmodule : psc_core_tb_top

`default_nettype wire
